// *** hdl/ext_edge_detect.sv ***
`timescale 1ns/1ps
`default_nettype none
module ext_edge_detect #(
	parameter int PINS = 8
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [PINS-1:0] pins_in,
	input wire logic [7:0] pin_sel_in,
	input wire logic edge_sel_in,
	output logic edge_out
);
	logic lvl_q, lvl_d, edge_d;
	// Unknown selections read as a quiet low pin
	always_comb begin
		lvl_d = (pin_sel_in < 8'(PINS)) ? pins_in[pin_sel_in[$clog2(PINS)-1:0]] : 1'b0; // RULE16
		edge_d = edge_sel_in ? (lvl_d & ~lvl_q) : (~lvl_d & lvl_q); // RULE14
	end
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			lvl_q <= 1'b0;
			edge_out <= 1'b0;
		end else begin
			lvl_q <= lvl_d;
			edge_out <= edge_d;
		end
	end
endmodule : ext_edge_detect
`default_nettype wire

// *** hdl/irq_pkg.sv ***
package irq_pkg;
	localparam int ADDR_W = 13;
	// Register indices; byte address is four times the index
	localparam logic [ADDR_W-1:0] IDX_INTCTL = 13'h000b;
	localparam logic [ADDR_W-1:0] IDX_EN0 = 13'h0716;
	localparam logic [ADDR_W-1:0] IDX_EN1 = 13'h0717;
	localparam logic [ADDR_W-1:0] IDX_REQ0 = 13'h070c;
	localparam logic [ADDR_W-1:0] IDX_REQ1 = 13'h070d;
	localparam logic [ADDR_W-1:0] IDX_PINSEL = 13'h1f70;
	localparam logic [ADDR_W-1:0] IDX_SHADOW = 13'h1fe4;
	localparam int SHADOW_N = 8;
	localparam int SH_WORKING_REG = 0;
	localparam int SH_STATUS = 1;
	localparam int SH_BSR = 2;
	localparam int SH_FSR0L = 3;
	localparam int SH_FSR0H = 4;
	localparam int SH_FSR1L = 5;
	localparam int SH_FSR1H = 6;
	localparam int SH_PC_LATCH_HIGH = 7;
	localparam int GIE_BIT = 7;
	localparam int PERIPHERAL_GROUP_ENABLE_BIT = 6;
	localparam int EDGE_BIT = 0;
	localparam int T0_BIT = 5;
	localparam int IOC_BIT = 4;
	localparam int EXT_BIT = 0;
	localparam logic [7:0] INTCTL_MASK = 8'hc1;
	localparam logic [7:0] EN0_MASK = 8'h31;
	localparam logic [7:0] REQ0_WMASK = 8'h21;
	localparam logic [7:0] STATUS_KEEP = 8'h18;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [14:0] VECTOR_ADDR = 15'h0004;
	localparam logic [1:0] PH_Q1 = 2'h0;
	localparam logic [1:0] PH_LAST = 2'h3;
	typedef enum logic [2:0] {
		S_RUN = 3'b001,
		S_SLEEP = 3'b010,
		S_POSTWAKE = 3'b100
	} run_state_t;
endpackage : irq_pkg

// *** hdl/irq_vector_ctrl.sv ***
// Functional notes
// RULE1: Any reset leaves global enable clear, so nothing vectors.
// RULE2: Vector needs global, individual and, for registers 1-2, group enable.
// RULE3: Register-0 sources ignore the group enable.
// RULE4: Request flags set on events whatever the enables.
// RULE5: On accept: flush, clear global enable, push PC, save context, load vector.
// RULE6: In the service routine events set flags but never vector.
// RULE7: Return pops, restores context and sets global enable.
// RULE8: Requests pending while disabled are served once global enable sets.
// RULE9: Firmware clears serviced flags before returning.
// RULE10: Requests sampled once per instruction cycle, at the first phase.
// RULE11: Latency 3-5 cycles asynchronous, 3-4 synchronous.
// RULE12: Firmware sets enables before sleep; only clockless sources wake.
// RULE13: After wake run next instruction, then vector if global enable set.
// RULE14: External pin is edge triggered, edge select 1 rising, 0 falling.
// RULE15: Valid pin edge sets its flag and vectors when enabled.
// RULE16: External input taken from the pin chosen by pin select.
// RULE17: Shadow working, status, bank, file select, pc latch; restore on return.
// RULE18: Shadows readable and writable in bank 63, written value restored.
// RULE19: Control register: global bit 7, group bit 6, edge select bit 0.
// RULE20: Enable register 0: timer0 bit 5, change bit 4, pin bit 0.
// RULE21: Enable register 1 holds eight peripheral enables, reset 0.
// RULE22: Firmware clears a flag before enabling its source.
// RULE23: Change summary flag is OR of all per-pin change flags.
// RULE24: Core request is OR of flag and enable, gated by group and global; the code ANDs each flag with its enable, then ORs the results.
// RULE25: Writing zero clears a flag; hardware set beats clear.
`timescale 1ns/1ps
`default_nettype none
module irq_vector_ctrl #(
	parameter int EXT_PINS = 8,
	parameter int IOC_N = 8
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic [irq_pkg::ADDR_W-1:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [3:0] avs_byteenable_in,
	input wire logic [31:0] avs_writedata_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	input wire logic [EXT_PINS-1:0] ext_pins_in,
	input wire logic tmr0_evt_in,
	input wire logic [IOC_N-1:0] ioc_flags_in,
	input wire logic [7:0] periph_evt_in,
	input wire logic sleep_enter_in,
	input wire logic return_from_interrupt_in,
	input wire logic [7:0] ctx_working_reg_in,
	input wire logic [7:0] ctx_status_in,
	input wire logic [7:0] ctx_bsr_in,
	input wire logic [7:0] ctx_fsr0l_in,
	input wire logic [7:0] ctx_fsr0h_in,
	input wire logic [7:0] ctx_fsr1l_in,
	input wire logic [7:0] ctx_fsr1h_in,
	input wire logic [7:0] ctx_pc_latch_high_in,
	output logic vector_take_out,
	output logic [14:0] vector_addr_out,
	output logic wake_out,
	output logic restore_take_out,
	output logic [7:0] restore_working_reg_out,
	output logic [7:0] restore_status_out,
	output logic [7:0] restore_bsr_out,
	output logic [7:0] restore_fsr0l_out,
	output logic [7:0] restore_fsr0h_out,
	output logic [7:0] restore_fsr1l_out,
	output logic [7:0] restore_fsr1h_out,
	output logic [7:0] restore_pc_latch_high_out
);
	localparam int SHADOW_N = irq_pkg::SHADOW_N;
	logic q1;
	logic ext_edge;
	logic [7:0] intctl_q, intctl_d;
	logic [7:0] en0_q, en0_d;
	logic [7:0] en1_q, en1_d;
	logic [7:0] req0_q, req0_d;
	logic [7:0] req1_q, req1_d;
	logic [7:0] pinsel_q, pinsel_d;
	logic [7:0] shadow_q [SHADOW_N];
	logic [7:0] shadow_d [SHADOW_N];
	logic [7:0] ctx [SHADOW_N];
	irq_pkg::run_state_t st_q, st_d;
	logic wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;
	logic take_q, take_d;
	logic wake_q, wake_d;
	logic rest_q, rest_d;
	logic [7:0] rest_val_q [SHADOW_N];
	logic [7:0] rest_val_d [SHADOW_N];
	logic wr_en, rd_en;
	logic pend0, pend1, req_any;
	logic global_irq_enable, peripheral_group_enable;

	qphase_gen u_qphase (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.q1_out(q1)
	);

	ext_edge_detect #(.PINS(EXT_PINS)) u_edge (
		.ref_clk_in(ref_clk_in),
		.rst_n_in(rst_n_in),
		.pins_in(ext_pins_in),
		.pin_sel_in(pinsel_q),
		.edge_sel_in(intctl_q[irq_pkg::EDGE_BIT]),
		.edge_out(ext_edge)
	);

	assign ctx[irq_pkg::SH_WORKING_REG] = ctx_working_reg_in;
	assign ctx[irq_pkg::SH_STATUS] = ctx_status_in;
	assign ctx[irq_pkg::SH_BSR] = ctx_bsr_in;
	assign ctx[irq_pkg::SH_FSR0L] = ctx_fsr0l_in;
	assign ctx[irq_pkg::SH_FSR0H] = ctx_fsr0h_in;
	assign ctx[irq_pkg::SH_FSR1L] = ctx_fsr1l_in;
	assign ctx[irq_pkg::SH_FSR1H] = ctx_fsr1h_in;
	assign ctx[irq_pkg::SH_PC_LATCH_HIGH] = ctx_pc_latch_high_in;

	assign global_irq_enable = intctl_q[irq_pkg::GIE_BIT];
	assign peripheral_group_enable = intctl_q[irq_pkg::PERIPHERAL_GROUP_ENABLE_BIT];
	// Access completes on the cycle waitrequest is low
	assign wr_en = avs_write_in && !wait_q && avs_byteenable_in[0];
	assign rd_en = avs_read_in && wait_q;

	// Request gating toward the core
	always_comb begin
		pend0 = |(req0_q & en0_q & irq_pkg::EN0_MASK); // RULE3
		pend1 = peripheral_group_enable && (|(req1_q & en1_q)); // RULE2
		req_any = pend0 || pend1; // RULE24
	end

	// Bus slave: one wait cycle, then answer
	always_comb begin
		wait_d = !((avs_read_in || avs_write_in) && wait_q);
		rdata_d = rdata_q;
		if (rd_en) begin
			rdata_d = 32'h0000_0000;
			case (avs_address_in)
				irq_pkg::IDX_INTCTL: rdata_d[7:0] = intctl_q;
				irq_pkg::IDX_EN0: rdata_d[7:0] = en0_q;
				irq_pkg::IDX_EN1: rdata_d[7:0] = en1_q;
				irq_pkg::IDX_REQ0: rdata_d[7:0] = req0_q;
				irq_pkg::IDX_REQ1: rdata_d[7:0] = req1_q;
				irq_pkg::IDX_PINSEL: rdata_d[7:0] = pinsel_q;
				default: begin
					for (int i = 0; i < SHADOW_N; i++) begin
						if (avs_address_in == irq_pkg::IDX_SHADOW + 13'(i)) begin
							rdata_d[7:0] = shadow_q[i]; // RULE18
						end
					end
				end
			endcase
		end
	end

	// Control, enables, flags
	always_comb begin
		intctl_d = intctl_q;
		en0_d = en0_q;
		en1_d = en1_q;
		req0_d = req0_q;
		req1_d = req1_q;
		pinsel_d = pinsel_q;
		if (wr_en) begin
			case (avs_address_in)
				irq_pkg::IDX_INTCTL: intctl_d = avs_writedata_in[7:0] & irq_pkg::INTCTL_MASK; // RULE19
				irq_pkg::IDX_EN0: en0_d = avs_writedata_in[7:0] & irq_pkg::EN0_MASK; // RULE20
				irq_pkg::IDX_EN1: en1_d = avs_writedata_in[7:0]; // RULE21
				irq_pkg::IDX_REQ0: req0_d = avs_writedata_in[7:0] & irq_pkg::REQ0_WMASK; // RULE25
				irq_pkg::IDX_REQ1: req1_d = avs_writedata_in[7:0]; // RULE25
				irq_pkg::IDX_PINSEL: pinsel_d = avs_writedata_in[7:0]; // RULE16
				default: ;
			endcase
		end
		// Hardware sets applied last so they beat a same-cycle clear
		req0_d[irq_pkg::T0_BIT] = req0_d[irq_pkg::T0_BIT] | tmr0_evt_in; // RULE4
		req0_d[irq_pkg::EXT_BIT] = req0_d[irq_pkg::EXT_BIT] | ext_edge; // RULE15
		// Summary is not software writable; it tracks the per-pin flags
		req0_d[irq_pkg::IOC_BIT] = |ioc_flags_in; // RULE23
		req1_d = req1_d | periph_evt_in; // RULE4
		if (return_from_interrupt_in) begin
			intctl_d[irq_pkg::GIE_BIT] = 1'b1; // RULE7
		end
		if (take_d) begin
			intctl_d[irq_pkg::GIE_BIT] = 1'b0; // RULE5
		end
	end

	// Vectoring, sleep and wake sequencing
	always_comb begin
		st_d = st_q;
		take_d = 1'b0;
		wake_d = 1'b0;
		case (st_q)
			irq_pkg::S_RUN: begin
				// Sampled at the first phase only; gie low blocks it
				if (sleep_enter_in) begin
					st_d = irq_pkg::S_SLEEP;
				end else if (q1 && global_irq_enable && req_any) begin // RULE6 RULE10
					take_d = 1'b1; // RULE8
				end
			end
			irq_pkg::S_SLEEP: begin
				// Enables alone wake; gie only decides the later branch
				if (pend0 || pend1) begin
					wake_d = 1'b1;
					st_d = irq_pkg::S_POSTWAKE;
				end
			end
			irq_pkg::S_POSTWAKE: begin
				// Holds off one instruction so the one after sleep runs
				if (q1) begin
					st_d = irq_pkg::S_RUN; // RULE13
				end
			end
			default: st_d = irq_pkg::S_RUN;
		endcase
	end

	// Shadow capture, software update and restore
	always_comb begin
		rest_d = return_from_interrupt_in;
		for (int i = 0; i < SHADOW_N; i++) begin
			shadow_d[i] = shadow_q[i];
			rest_val_d[i] = rest_val_q[i];
			if (take_d) begin
				shadow_d[i] = ctx[i]; // RULE17
			end else if (wr_en && avs_address_in == irq_pkg::IDX_SHADOW + 13'(i)) begin
				shadow_d[i] = avs_writedata_in[7:0]; // RULE18
			end
			if (return_from_interrupt_in) begin
				rest_val_d[i] = shadow_q[i]; // RULE7
			end
		end
		// Time-out and power-down stay live, never restored
		if (return_from_interrupt_in) begin
			rest_val_d[irq_pkg::SH_STATUS] = (shadow_q[irq_pkg::SH_STATUS] & ~irq_pkg::STATUS_KEEP)
				| (ctx_status_in & irq_pkg::STATUS_KEEP); // RULE17
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			intctl_q <= irq_pkg::RST_BYTE; // RULE1
			en0_q <= irq_pkg::RST_BYTE;
			en1_q <= irq_pkg::RST_BYTE; // RULE21
			req0_q <= irq_pkg::RST_BYTE;
			req1_q <= irq_pkg::RST_BYTE;
			pinsel_q <= irq_pkg::RST_BYTE;
			st_q <= irq_pkg::S_RUN;
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			take_q <= 1'b0;
			wake_q <= 1'b0;
			rest_q <= 1'b0;
			for (int i = 0; i < SHADOW_N; i++) begin
				shadow_q[i] <= irq_pkg::RST_BYTE;
				rest_val_q[i] <= irq_pkg::RST_BYTE;
			end
		end else begin
			intctl_q <= intctl_d;
			en0_q <= en0_d;
			en1_q <= en1_d;
			req0_q <= req0_d;
			req1_q <= req1_d;
			pinsel_q <= pinsel_d;
			st_q <= st_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			take_q <= take_d;
			wake_q <= wake_d;
			rest_q <= rest_d;
			for (int i = 0; i < SHADOW_N; i++) begin
				shadow_q[i] <= shadow_d[i];
				rest_val_q[i] <= rest_val_d[i];
			end
		end
	end

	// Core flushes, pushes PC and jumps; its pipeline adds the latency
	assign vector_take_out = take_q; // RULE5
	assign vector_addr_out = irq_pkg::VECTOR_ADDR; // RULE11
	assign wake_out = wake_q;
	assign restore_take_out = rest_q;
	assign avs_waitrequest_out = wait_q;
	assign avs_readdata_out = rdata_q;
	assign restore_working_reg_out = rest_val_q[irq_pkg::SH_WORKING_REG];
	assign restore_status_out = rest_val_q[irq_pkg::SH_STATUS];
	assign restore_bsr_out = rest_val_q[irq_pkg::SH_BSR];
	assign restore_fsr0l_out = rest_val_q[irq_pkg::SH_FSR0L];
	assign restore_fsr0h_out = rest_val_q[irq_pkg::SH_FSR0H];
	assign restore_fsr1l_out = rest_val_q[irq_pkg::SH_FSR1L];
	assign restore_fsr1h_out = rest_val_q[irq_pkg::SH_FSR1H];
	assign restore_pc_latch_high_out = rest_val_q[irq_pkg::SH_PC_LATCH_HIGH];

	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);

	vec_needs_gie_a: assert property ($rose(take_q) |-> $past(global_irq_enable) && $past(q1)) // RULE10
		else $error("vector taken without global enable at first phase");
	vec_clears_gie_a: assert property (take_q |-> !global_irq_enable) // RULE5
		else $error("global enable still set after vectoring");
	vec_needs_group_a: assert property (take_q && !$past(pend0) |-> $past(peripheral_group_enable)) // RULE2
		else $error("peripheral vector without group enable");
	ret_sets_gie_a: assert property (return_from_interrupt_in && !take_d |=> global_irq_enable && rest_q) // RULE7
		else $error("return did not set global enable");
	ret_restores_a: assert property (return_from_interrupt_in |=> // RULE17
		restore_working_reg_out == $past(shadow_q[irq_pkg::SH_WORKING_REG]))
		else $error("working register not restored from shadow");
	ext_flag_set_a: assert property (ext_edge |=> req0_q[irq_pkg::EXT_BIT]) // RULE15
		else $error("pin edge did not set its flag");
	set_beats_clear_a: assert property (tmr0_evt_in |=> req0_q[irq_pkg::T0_BIT]) // RULE25
		else $error("timer event lost against clear");
	summary_or_a: assert property (##1 req0_q[irq_pkg::IOC_BIT] == $past(|ioc_flags_in)) // RULE23
		else $error("change summary is not OR of pin flags");
	no_vec_asleep_a: assert property (take_q |-> $past(st_q) == irq_pkg::S_RUN) // RULE13
		else $error("vector while asleep or just woken");
	pending_served_a: assert property (global_irq_enable && req_any && st_q == irq_pkg::S_RUN // RULE8
		&& !sleep_enter_in |-> ##[1:5] !global_irq_enable)
		else $error("pending enabled request not served");

	// Gating and sequencing hazards the bench reaches only indirectly
	core_no_group_a: assert property (q1 && global_irq_enable && pend0 && !peripheral_group_enable // RULE3
		&& st_q == irq_pkg::S_RUN && !sleep_enter_in |=> take_q)
		else $error("register-0 source blocked by group enable");
	periph_flag_set_a: assert property (|periph_evt_in |=> // RULE4
		(req1_q & $past(periph_evt_in)) == $past(periph_evt_in))
		else $error("peripheral event did not set its flag");
	isr_no_vector_a: assert property (!global_irq_enable |=> !take_q) // RULE6
		else $error("vector taken while global enable clear");
	post_wake_hold_a: assert property (st_q == irq_pkg::S_POSTWAKE |=> !take_q) // RULE13
		else $error("vector before the instruction after sleep");
	req_gate_a: assert property (take_q |-> $past(req_any)) // RULE24
		else $error("vector with no enabled request");
	ret_pulse_a: assert property (rest_q |-> $past(return_from_interrupt_in)) // RULE7
		else $error("restore pulse without a return");

	// Main scenarios the bench should reach
	peripheral_group_enable_gate_c: cover property (global_irq_enable && !peripheral_group_enable && |(req1_q & en1_q));

	vec_seen_c: cover property (take_q);
	ret_seen_c: cover property (rest_q ##[1:20] take_q);
	wake_seen_c: cover property (wake_q ##[1:12] take_q);
	ext_seen_c: cover property (ext_edge ##[1:8] take_q);
endmodule : irq_vector_ctrl
`default_nettype wire

// *** hdl/qphase_gen.sv ***
`timescale 1ns/1ps
`default_nettype none
module qphase_gen (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	output logic q1_out
);
	logic [1:0] ph_q, ph_d;
	logic q1_d;
	// Four clocks make one instruction cycle
	always_comb begin
		ph_d = (ph_q == irq_pkg::PH_LAST) ? irq_pkg::PH_Q1 : ph_q + 2'h1;
		q1_d = (ph_d == irq_pkg::PH_Q1);
	end
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ph_q <= irq_pkg::PH_LAST;
			q1_out <= 1'b0;
		end else begin
			ph_q <= ph_d;
			q1_out <= q1_d;
		end
	end
endmodule : qphase_gen
`default_nettype wire

// *** testbench/core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module core_model (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic vector_take_in,
	input wire logic ret_cmd_in,
	input wire logic sleep_cmd_in,
	output logic return_out,
	output logic sleep_out,
	output logic [7:0] ctx_out [8]
);
	// Routine scribbles on live context, so a missing restore shows up
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			return_out <= 1'b0;
			sleep_out <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				ctx_out[i] <= 8'h10 + 8'(i);
			end
		end else begin
			return_out <= ret_cmd_in;
			sleep_out <= sleep_cmd_in;
			if (vector_take_in) begin
				for (int i = 0; i < 8; i++) begin
					ctx_out[i] <= ~ctx_out[i];
				end
			end
		end
	end
endmodule : core_model
`default_nettype wire

// *** testbench/mcu_interrupt_vectoring_logic_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
	$display("MISMATCH %0t got %h want %h", $time, (a), (e)); end end
module mcu_interrupt_vectoring_logic_tb_top;
	logic clk, rst_n, rd, wr, tmr0, ret_cmd, sleep_cmd, wt, vt, wake, rt, ret_p, slp_p;
	logic [12:0] addr;
	logic [3:0] be;
	logic [31:0] wdata, rdata;
	logic [7:0] pins, ioc, pevt, rs_w, rs_s, rs_b;
	logic [7:0] ctx [8];
	logic [7:0] rs_x [5];
	logic [14:0] va;
	int fail_count, n_tests, cyc;
	bit seen;
	core_model partner (.ref_clk_in(clk), .rst_n_in(rst_n), .vector_take_in(vt),
		.ret_cmd_in(ret_cmd), .sleep_cmd_in(sleep_cmd), .return_out(ret_p),
		.sleep_out(slp_p), .ctx_out(ctx));
	irq_vector_ctrl dut (.ref_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(addr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_byteenable_in(be),
		.avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(wt),
		.ext_pins_in(pins), .tmr0_evt_in(tmr0), .ioc_flags_in(ioc), .periph_evt_in(pevt),
		.sleep_enter_in(slp_p), .return_from_interrupt_in(ret_p), .ctx_working_reg_in(ctx[0]),
		.ctx_status_in(ctx[1]), .ctx_bsr_in(ctx[2]), .ctx_fsr0l_in(ctx[3]),
		.ctx_fsr0h_in(ctx[4]), .ctx_fsr1l_in(ctx[5]), .ctx_fsr1h_in(ctx[6]),
		.ctx_pc_latch_high_in(ctx[7]), .vector_take_out(vt), .vector_addr_out(va),
		.wake_out(wake), .restore_take_out(rt), .restore_working_reg_out(rs_w),
		.restore_status_out(rs_s), .restore_bsr_out(rs_b), .restore_fsr0l_out(rs_x[0]),
		.restore_fsr0h_out(rs_x[1]), .restore_fsr1l_out(rs_x[2]), .restore_fsr1h_out(rs_x[3]),
		.restore_pc_latch_high_out(rs_x[4]));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : complete_run
	// Generous ceiling, the whole sequence needs a few hundred cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			complete_run();
		end
	end
	task automatic bus(input logic w_en, input logic [12:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk);
		addr <= a;
		wdata <= {24'h000000, d};
		wr <= w_en;
		rd <= !w_en;
		// Only the bench ceiling ends a hung wait
		do begin
			@(posedge clk);
		end while (wt !== 1'b0);
		q = rdata[7:0];
		`CHK(rdata[31:8], 24'h000000)
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : bus
	task automatic w(input logic [12:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask : w
	task automatic rchk(input logic [12:0] a, input logic [7:0] e);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		`CHK(q, e)
	endtask : rchk
	task automatic wait_on(input int sel, input int lim);
		seen = 0;
		for (int i = 0; i < lim && !seen; i++) begin
			@(posedge clk);
			seen = (sel == 0) ? (vt === 1'b1) : (sel == 1) ? (rt === 1'b1) : (wake === 1'b1);
		end
	endtask : wait_on
	task automatic evt(input logic t, input logic [7:0] p);
		tmr0 <= t;
		pevt <= p;
		@(posedge clk);
		tmr0 <= 1'b0;
		pevt <= 8'h00;
	endtask : evt
	task automatic pin(input int i, input logic v);
		pins[i] <= v;
		repeat (3) @(posedge clk);
	endtask : pin
	task automatic t_regs();
		rchk(irq_pkg::IDX_INTCTL, 8'h00);
		rchk(irq_pkg::IDX_EN1, 8'h00);
		rchk(13'h0100, 8'h00);
		w(irq_pkg::IDX_INTCTL, 8'hff);
		rchk(irq_pkg::IDX_INTCTL, 8'hc1);
		w(irq_pkg::IDX_INTCTL, 8'h00);
		w(irq_pkg::IDX_EN0, 8'hff);
		rchk(irq_pkg::IDX_EN0, 8'h31);
		w(irq_pkg::IDX_EN1, 8'hff);
		be <= 4'h0;
		w(irq_pkg::IDX_EN1, 8'h00);
		be <= 4'h1;
		rchk(irq_pkg::IDX_EN1, 8'hff);
		w(irq_pkg::IDX_EN0, 8'h00);
		w(irq_pkg::IDX_EN1, 8'h00);
		w(irq_pkg::IDX_INTCTL, 8'h80);
		evt(1'b1, 8'hff);
		wait_on(0, 16);
		`CHK(seen, 1'b0)
		rchk(irq_pkg::IDX_REQ0, 8'h20);
		rchk(irq_pkg::IDX_REQ1, 8'hff);
		w(irq_pkg::IDX_REQ1, 8'h00);
		w(irq_pkg::IDX_REQ0, 8'h00);
		rchk(irq_pkg::IDX_REQ1, 8'h00);
		// Timer pulse lands in the write's completing cycle
		fork
			w(irq_pkg::IDX_REQ0, 8'h00);
			begin
				repeat (2) @(posedge clk);
				evt(1'b1, 8'h00);
			end
		join
		rchk(irq_pkg::IDX_REQ0, 8'h20);
		w(irq_pkg::IDX_REQ0, 8'h00);
		$display("test regs done");
	endtask : t_regs
	task automatic t_vector();
		w(irq_pkg::IDX_EN0, 8'h20);
		evt(1'b1, 8'h00);
		wait_on(0, 8);
		`CHK(seen, 1'b1)
		`CHK(va, irq_pkg::VECTOR_ADDR)
		rchk(irq_pkg::IDX_INTCTL, 8'h00);
		rchk(irq_pkg::IDX_SHADOW, 8'h10);
		rchk(irq_pkg::IDX_SHADOW + 13'h0002, 8'h12);
		w(irq_pkg::IDX_EN1, 8'h01);
		w(irq_pkg::IDX_INTCTL, 8'h40);
		evt(1'b0, 8'h01);
		wait_on(0, 12);
		`CHK(seen, 1'b0)
		rchk(irq_pkg::IDX_REQ1, 8'h01);
		w(irq_pkg::IDX_SHADOW, 8'h5a);
		w(irq_pkg::IDX_REQ0, 8'h00);
		ret_cmd <= 1'b1;
		@(posedge clk);
		ret_cmd <= 1'b0;
		wait_on(1, 8);
		`CHK(seen, 1'b1)
		`CHK(rs_w, 8'h5a)
		`CHK(rs_b, 8'h12)
		for (int i = 0; i < 5; i++) `CHK(rs_x[i], 8'h13 + 8'(i))
		`CHK(rs_s, (8'h11 & ~irq_pkg::STATUS_KEEP) | (8'hee & irq_pkg::STATUS_KEEP))
		wait_on(0, 12);
		`CHK(seen, 1'b1)
		w(irq_pkg::IDX_REQ1, 8'h00);
		w(irq_pkg::IDX_EN1, 8'h80);
		w(irq_pkg::IDX_INTCTL, 8'h80);
		evt(1'b0, 8'h80);
		wait_on(0, 16);
		`CHK(seen, 1'b0)
		w(irq_pkg::IDX_INTCTL, 8'hc0);
		wait_on(0, 12);
		`CHK(seen, 1'b1)
		w(irq_pkg::IDX_REQ1, 8'h00);
		w(irq_pkg::IDX_EN1, 8'h00);
		w(irq_pkg::IDX_EN0, 8'h00);
		$display("test vector done");
	endtask : t_vector
	task automatic t_pin();
		w(irq_pkg::IDX_PINSEL, 8'h03);
		w(irq_pkg::IDX_INTCTL, 8'h01);
		pin(5, 1'b1);
		rchk(irq_pkg::IDX_REQ0, 8'h00);
		pin(3, 1'b1);
		rchk(irq_pkg::IDX_REQ0, 8'h01);
		w(irq_pkg::IDX_REQ0, 8'h00);
		pin(3, 1'b0);
		rchk(irq_pkg::IDX_REQ0, 8'h00);
		w(irq_pkg::IDX_INTCTL, 8'h00);
		pin(3, 1'b1);
		rchk(irq_pkg::IDX_REQ0, 8'h00);
		pin(3, 1'b0);
		rchk(irq_pkg::IDX_REQ0, 8'h01);
		w(irq_pkg::IDX_REQ0, 8'h00);
		w(irq_pkg::IDX_EN0, 8'h01);
		w(irq_pkg::IDX_INTCTL, 8'h80);
		pin(3, 1'b1);
		pin(3, 1'b0);
		wait_on(0, 12);
		`CHK(seen, 1'b1)
		w(irq_pkg::IDX_REQ0, 8'h00);
		$display("test pin done");
	endtask : t_pin
	task automatic t_sleep(input logic [7:0] ctl, input bit expect_vec);
		w(irq_pkg::IDX_INTCTL, ctl);
		pin(3, 1'b1);
		sleep_cmd <= 1'b1;
		@(posedge clk);
		sleep_cmd <= 1'b0;
		pin(3, 1'b0);
		wait_on(2, 8);
		`CHK(seen, 1'b1)
		wait_on(0, 16);
		`CHK(seen, expect_vec)
		w(irq_pkg::IDX_REQ0, 8'h00);
		$display("test sleep done");
	endtask : t_sleep
	task automatic t_change();
		ioc <= 8'h81;
		rchk(irq_pkg::IDX_REQ0, 8'h10);
		ioc <= 8'h01;
		rchk(irq_pkg::IDX_REQ0, 8'h10);
		ioc <= 8'h00;
		rchk(irq_pkg::IDX_REQ0, 8'h00);
		$display("test change done");
	endtask : t_change
	initial begin
		rst_n = 1'b0;
		{rd, wr, tmr0, ret_cmd, sleep_cmd} = 5'h00;
		addr = 13'h0000;
		be = 4'h1;
		wdata = 32'h00000000;
		{pins, ioc, pevt} = 24'h000000;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_vector();
		t_pin();
		t_sleep(8'h00, 1'b0);
		t_sleep(8'h80, 1'b1);
		t_change();
		complete_run();
	end
endmodule : mcu_interrupt_vectoring_logic_tb_top
`default_nettype wire
